// [design/sfd_pkg.sv]
// Package: opcodes, sizes, states and command pulses of the flash front end
package sfd_pkg;

  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_READ = 8'h03;     // Normal single-lane read
  localparam logic [7:0] OP_FAST = 8'h0b;     // Fast single-lane read
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;  // Two-lane address and data
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b; // Two-lane data only
  localparam logic [7:0] OP_QUAD_IO = 8'heb;  // Four-lane address and data
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b; // Four-lane data only
  localparam logic [7:0] OP_PAGE = 8'h02;     // Single-lane page write
  localparam logic [7:0] OP_QPAGE_A = 8'h32;  // Four-lane page write
  localparam logic [7:0] OP_QPAGE_B = 8'h38;  // Four-lane page write, alias
  localparam logic [7:0] OP_ERASE_A = 8'hc7;  // Whole-array erase
  localparam logic [7:0] OP_ERASE_B = 8'h60;  // Whole-array erase, alias
  localparam logic [7:0] OP_SUSP_A = 8'h75;   // Suspend program or erase
  localparam logic [7:0] OP_SUSP_B = 8'hb0;   // Suspend, alias
  localparam logic [7:0] OP_SLEEP = 8'hb9;    // Enter deep power-down
  localparam logic [7:0] OP_WAKE_ID = 8'hab;  // Wake and identify
  localparam logic [7:0] OP_JEDEC = 8'h9f;    // Standard identification
  localparam logic [7:0] OP_LATCH_SET = 8'h06; // Set write latch
  localparam logic [7:0] OP_RST_EN = 8'h66;   // Arm software reset
  localparam logic [7:0] OP_RST = 8'h99;      // Software reset

  // ==========================================================
  // Sizes and counts
  localparam int BYTE_W = 8;                  // Data byte width
  localparam int DEF_ADDR_W = 19;             // Decoded address bits
  localparam int FIFO_DEPTH = 8;              // Read prefetch depth
  localparam logic [4:0] OPC_LAST = 5'h07;    // Last opcode bit index
  localparam logic [4:0] ADDR_LAST = 5'h17;   // Last of 24 address bits
  localparam logic [2:0] BIT_FIRST = 3'h0;    // Bit slot that loads a byte

  // ==========================================================
  // Values after reset
  localparam logic LATCH_RST = 1'b0;          // Write latch clear
  localparam logic SLEEP_RST = 1'b0;          // Awake

  // ==========================================================
  // Sequence states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,                       // Deselected
    ST_OPC = 5'b00010,                        // Shifting opcode
    ST_ADDR = 5'b00100,                       // Shifting read address
    ST_DATA = 5'b01000,                       // Streaming read data
    ST_SKIP = 5'b10000                        // Ignoring rest of frame
  } sfd_state_t;

  // Decoded command pulses
  typedef struct packed {
    logic read_cmd;               // Normal read started
    logic fast_single_read_cmd;   // Fast read seen
    logic dual_io_read_cmd;       // Two-lane io read seen
    logic dual_out_read_cmd;      // Two-lane output read seen
    logic quad_io_read_cmd;       // Four-lane io read seen
    logic quad_out_read_cmd;      // Four-lane output read seen
    logic page_write_cmd;         // Page write accepted
    logic quad_page_write_cmd;    // Four-lane page write accepted
    logic whole_array_erase_cmd;  // Whole erase accepted
    logic suspend_op_cmd;         // Suspend request
    logic deep_sleep_cmd;         // Entered deep power-down
    logic wake_and_id_cmd;        // Wake and identify
    logic jedec_id_fetch_cmd;     // Standard identification
  } sfd_cmd_t;

endpackage

// [design/sfd_flash_front.sv]
// Flash front end: pin sampling, opcode decode, normal read with prefetch FIFO

// ============================================================
// Prefetch FIFO
module sfd_fifo #(
  parameter int WIDTH = 8,                    // Word width
  parameter int DEPTH = 8                     // Word count
) (
  input wire logic i_clk,                     // System clock
  input wire logic i_rst,                     // Async reset
  input wire logic i_ce,                      // Clock enable
  input wire logic i_flush,                   // Drop contents
  input wire logic i_valid,                   // Write request
  output logic o_ready,                       // Room for a word
  input wire logic [WIDTH-1:0] i_data,        // Write word
  output logic o_valid,                       // Word available
  input wire logic i_ready,                   // Read accept
  output logic [WIDTH-1:0] o_data             // Head word
);
  localparam int PW = $clog2(DEPTH);          // Pointer width
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH); // Full count, one bit wider than pointers

  logic [WIDTH-1:0] mem_r [DEPTH];            // Storage
  logic [PW-1:0] wr_r;                        // Write pointer
  logic [PW-1:0] rd_r;                        // Read pointer
  logic [PW:0] cnt_r;                         // Fill level
  logic push;                                 // Write takes place
  logic pop;                                  // Read takes place

  assign o_ready = (cnt_r != FULL);
  assign o_valid = (cnt_r != '0);
  assign o_data = mem_r[rd_r];
  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;

  // Storage write, no reset needed
  always_ff @(posedge i_clk) begin
    if (i_ce && push && !i_flush) begin
      mem_r[wr_r] <= i_data;
    end
  end

  // Pointers and level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_r <= '0;
        rd_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) begin
          wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
          rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
        end
        cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
    end
  end
endmodule

module sfd_flash_front
#(
  parameter int ADDR_W = sfd_pkg::DEF_ADDR_W,   // Decoded address bits
  parameter bit HAS_ERASE = 1'b1               // Whole erase supported
) (
  input wire logic i_clk,                       // System clock
  input wire logic i_rst,                       // Async reset, high
  input wire logic i_ce,                        // Clock enable
  input wire logic i_sck,                       // Link clock pin
  input wire logic i_cs_n,                      // Chip select, low
  input wire logic i_lane0,                     // Serial data in
  output logic o_lane1_out,                     // Serial data out
  output logic o_lane1_oe,                      // Data out drive
  output logic o_mem_rd,                        // Array read pulse
  output logic [ADDR_W-1:0] o_mem_addr,         // Array read address
  input wire logic [sfd_pkg::BYTE_W-1:0] i_mem_data, // Array byte
  input wire logic i_mem_valid,                 // Array byte valid
  input wire logic i_op_in_progress,            // Long operation busy
  output sfd_pkg::sfd_cmd_t o_cmd,              // Command pulses
  output logic [7:0] o_opcode,                  // Instruction register
  output logic o_write_latch,                   // Write latch state
  output logic o_sleep,                         // Deep power-down
  output logic o_soft_rst                       // Software reset pulse
);
  import sfd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sck_sy_r;                         // SCK sync chain
  logic [2:0] cs_sy_r;                          // Select sync chain
  logic [2:0] si_sy_r;                          // Data sync chain
  logic sck_lvl_r;                              // Accepted SCK level
  logic cs_lvl_r;                               // Accepted select level
  logic sck_rise;                               // SCK rising event
  logic sck_fall;                               // SCK falling event
  logic cs_rise;                                // Deselect event
  logic cs_fall;                                // Select event

  // Three-stage chains, second and third must agree for SCK and select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_sy_r <= 3'h0;
      cs_sy_r <= 3'h7;
      si_sy_r <= 3'h0;
    end else if (i_ce) begin
      sck_sy_r <= {sck_sy_r[1:0], i_sck};
      cs_sy_r <= {cs_sy_r[1:0], i_cs_n};
      si_sy_r <= {si_sy_r[1:0], i_lane0};
    end
  end

  // Accepted levels follow agreed samples
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_lvl_r <= 1'b0;
      cs_lvl_r <= 1'b1;
    end else if (i_ce) begin
      if (sck_sy_r[1] == sck_sy_r[2]) begin
        sck_lvl_r <= sck_sy_r[2];
      end
      if (cs_sy_r[1] == cs_sy_r[2]) begin
        cs_lvl_r <= cs_sy_r[2];
      end
    end
  end

  // Edge events, one cycle each
  assign sck_rise = (sck_sy_r[1] == sck_sy_r[2]) && sck_sy_r[2] && !sck_lvl_r;
  assign sck_fall = (sck_sy_r[1] == sck_sy_r[2]) && !sck_sy_r[2] && sck_lvl_r;
  assign cs_rise = (cs_sy_r[1] == cs_sy_r[2]) && cs_sy_r[2] && !cs_lvl_r;
  assign cs_fall = (cs_sy_r[1] == cs_sy_r[2]) && !cs_sy_r[2] && cs_lvl_r;

  // ==========================================================
  // Sequence and instruction register
  sfd_state_t state_r;                          // Sequence state
  logic [4:0] cnt_r;                            // Bit counter
  logic [6:0] opc_sh_r;                         // Opcode shifter
  logic [22:0] addr_sh_r;                       // Address shifter
  logic [ADDR_W-1:0] start_addr_r;              // Decoded start address
  logic addr_done_r;                            // Address phase ended
  logic [7:0] opc_nxt;                          // Completed opcode
  logic opc_end;                                // Opcode bit eight taken
  logic sleep_r;                                // Deep power-down flag
  logic latch_r;                                // Write latch
  logic read_go;                                // Normal read may start

  assign opc_nxt = {opc_sh_r, si_sy_r[2]};      // MSB first
  assign opc_end = (state_r == ST_OPC) && sck_rise && (cnt_r == OPC_LAST);
  assign read_go = (opc_nxt == OP_READ) && !i_op_in_progress && !sleep_r;

  // Frame walk: opcode, address, data or skip
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      opc_sh_r <= '0;
      addr_sh_r <= '0;
      start_addr_r <= '0;
      addr_done_r <= 1'b0;
      o_opcode <= '0;
    end else if (i_ce) begin
      addr_done_r <= 1'b0;
      if (cs_rise) begin
        state_r <= ST_IDLE;
      end else if (cs_fall) begin
        state_r <= ST_OPC;
        cnt_r <= '0;
      end else if (sck_rise && !cs_lvl_r) begin
        case (state_r)
          ST_OPC: begin
            opc_sh_r <= opc_nxt[6:0];
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == OPC_LAST) begin
              o_opcode <= opc_nxt;
              cnt_r <= '0;
              // Busy or asleep drops the read
              state_r <= read_go ? ST_ADDR : ST_SKIP;
            end
          end
          ST_ADDR: begin
            addr_sh_r <= {addr_sh_r[21:0], si_sy_r[2]};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == ADDR_LAST) begin
              // Upper address bits dropped
              start_addr_r <= ADDR_W'({addr_sh_r, si_sy_r[2]});
              addr_done_r <= 1'b1;
              state_r <= ST_DATA;
            end
          end
          ST_DATA: state_r <= ST_DATA;
          ST_SKIP: state_r <= ST_SKIP;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Opcode decode, write latch, power-down
  logic rst_arm_r;                              // Reset armed by 66h

  // Decode pulses and mode flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd <= '0;
      latch_r <= LATCH_RST;
      sleep_r <= SLEEP_RST;
      rst_arm_r <= 1'b0;
      o_soft_rst <= 1'b0;
    end else if (i_ce) begin
      o_cmd <= '0;
      o_soft_rst <= 1'b0;
      if (opc_end && sleep_r) begin
        // Only the wake opcode is heard in power-down
        if (opc_nxt == OP_WAKE_ID) begin
          sleep_r <= 1'b0;
          o_cmd.wake_and_id_cmd <= 1'b1;
        end
      end else if (opc_end) begin
        rst_arm_r <= (opc_nxt == OP_RST_EN);
        case (opc_nxt)
          OP_READ: o_cmd.read_cmd <= read_go;
          OP_FAST: o_cmd.fast_single_read_cmd <= !i_op_in_progress;
          OP_DUAL_IO: o_cmd.dual_io_read_cmd <= !i_op_in_progress;
          OP_DUAL_OUT: o_cmd.dual_out_read_cmd <= !i_op_in_progress;
          OP_QUAD_IO: o_cmd.quad_io_read_cmd <= !i_op_in_progress;
          OP_QUAD_OUT: o_cmd.quad_out_read_cmd <= !i_op_in_progress;
          OP_PAGE: begin
            o_cmd.page_write_cmd <= latch_r;
            latch_r <= 1'b0;
          end
          OP_QPAGE_A, OP_QPAGE_B: begin
            o_cmd.quad_page_write_cmd <= latch_r;
            latch_r <= 1'b0;
          end
          OP_ERASE_A, OP_ERASE_B: begin
            o_cmd.whole_array_erase_cmd <= latch_r && HAS_ERASE;
            latch_r <= 1'b0;
          end
          OP_SUSP_A, OP_SUSP_B: o_cmd.suspend_op_cmd <= 1'b1;
          OP_SLEEP: begin
            sleep_r <= 1'b1;
            o_cmd.deep_sleep_cmd <= 1'b1;
          end
          OP_WAKE_ID: o_cmd.wake_and_id_cmd <= 1'b1;
          OP_JEDEC: o_cmd.jedec_id_fetch_cmd <= 1'b1;
          OP_LATCH_SET: latch_r <= 1'b1;
          OP_RST: begin
            // Reset only when armed just before
            if (rst_arm_r) begin
              o_soft_rst <= 1'b1;
              latch_r <= LATCH_RST;
              sleep_r <= SLEEP_RST;
            end
          end
          default: o_cmd <= '0;
        endcase
      end
    end
  end

  assign o_write_latch = latch_r;
  assign o_sleep = sleep_r;

  // ==========================================================
  // Array prefetch into FIFO
  logic [ADDR_W-1:0] fetch_addr_r;              // Next byte to fetch
  logic pend_r;                                 // Fetch outstanding
  logic fifo_in_rdy;                            // FIFO has room
  logic fifo_out_vld;                           // FIFO has a byte
  logic [BYTE_W-1:0] fifo_dout;                 // Head byte
  logic fifo_push;                              // Byte arrives in frame
  logic sh_load;                                // Byte slot begins
  logic in_data;                                // Streaming now

  assign in_data = (state_r == ST_DATA) && !cs_rise;
  assign fifo_push = i_mem_valid && pend_r && in_data;

  // One fetch at a time, each fetch one address on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fetch_addr_r <= '0;
      pend_r <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_addr <= '0;
    end else if (i_ce) begin
      o_mem_rd <= 1'b0;
      if (i_mem_valid || !in_data) begin
        pend_r <= 1'b0;
      end
      if (addr_done_r) begin
        o_mem_rd <= 1'b1;
        o_mem_addr <= start_addr_r;
        fetch_addr_r <= start_addr_r + 1'b1;
        pend_r <= 1'b1;
      end else if (in_data && !pend_r && fifo_in_rdy) begin
        o_mem_rd <= 1'b1;
        o_mem_addr <= fetch_addr_r;
        // Natural overflow wraps to zero
        fetch_addr_r <= fetch_addr_r + 1'b1;
        pend_r <= 1'b1;
      end
    end
  end

  sfd_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_flush(!in_data),
    .i_valid(fifo_push),
    .o_ready(fifo_in_rdy),
    .i_data(i_mem_data),
    .o_valid(fifo_out_vld),
    .i_ready(sh_load),
    .o_data(fifo_dout)
  );

  // ==========================================================
  // Serial output shifter
  logic [2:0] bit_pos_r;                        // Bit slot in byte
  logic [6:0] out_sh_r;                         // Remaining bits

  assign sh_load = in_data && sck_fall && (bit_pos_r == BIT_FIRST);

  // Drive on falling SCK, MSB first
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_pos_r <= '0;
      out_sh_r <= '0;
      o_lane1_out <= 1'b0;
      o_lane1_oe <= 1'b0;
    end else if (i_ce) begin
      if (!in_data) begin
        bit_pos_r <= '0;
        o_lane1_oe <= 1'b0;
      end else if (sck_fall) begin
        bit_pos_r <= bit_pos_r + 3'h1;
        o_lane1_oe <= 1'b1;
        if (bit_pos_r == BIT_FIRST) begin
          // Empty FIFO sends zeros rather than stalling
          o_lane1_out <= fifo_out_vld && fifo_dout[7];
          out_sh_r <= fifo_out_vld ? fifo_dout[6:0] : 7'h00;
        end else begin
          o_lane1_out <= out_sh_r[6];
          out_sh_r <= {out_sh_r[5:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_cs_ends_drive: assert property (i_ce && cs_rise |=> !o_lane1_oe && state_r == ST_IDLE)
    else $error("data still driven after deselect");
  a_busy_read_drop: assert property (i_ce && opc_end && opc_nxt == OP_READ && i_op_in_progress
      |=> state_r == ST_SKIP && !o_cmd.read_cmd)
    else $error("read accepted while busy");
  a_read_to_addr: assert property (i_ce && !cs_rise && opc_end && read_go
      |=> state_r == ST_ADDR && o_opcode == OP_READ)
    else $error("normal read did not enter address phase");
  a_first_fetch: assert property (i_ce && addr_done_r
      |=> o_mem_rd && o_mem_addr == $past(start_addr_r))
    else $error("first fetch not at decoded address");
  a_fetch_wrap: assert property (o_mem_rd && (&o_mem_addr) |-> fetch_addr_r == '0)
    else $error("address did not wrap to zero");
  a_msb_first: assert property (i_ce && sh_load && fifo_out_vld
      |=> o_lane1_out == $past(fifo_dout[7]) && o_lane1_oe)
    else $error("byte did not start with its top bit");
  a_data_holds: assert property (i_ce && state_r == ST_DATA && !cs_rise |=> state_r == ST_DATA)
    else $error("serial input disturbed the data phase");
  a_latch_gate: assert property (i_ce && opc_end && !sleep_r && opc_nxt == OP_PAGE && !latch_r
      |=> !o_cmd.page_write_cmd)
    else $error("page write accepted without write latch");
  a_sleep_deaf: assert property (i_ce && opc_end && sleep_r && opc_nxt == OP_JEDEC
      |=> !o_cmd.jedec_id_fetch_cmd && o_sleep)
    else $error("command heard during power-down");
  a_wake_clears: assert property (i_ce && opc_end && opc_nxt == OP_WAKE_ID
      |=> !o_sleep && o_cmd.wake_and_id_cmd)
    else $error("wake opcode did not wake");
endmodule

// [verification/sfd_host_model.sv]
// Host serial controller model: select, link clock and data toward the flash front end
module sfd_host_model (
  input wire logic i_clk,        // Pacing clock
  input wire logic i_lane1_out,  // Device serial data out
  input wire logic i_lane1_oe,   // Device drives serial out
  output logic o_sck,            // Link clock, idle low
  output logic o_cs_n,           // Chip select, low
  output logic o_lane0           // Serial data to device
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels at time zero
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_lane0 = 1'b0;
  end

  // Select change with four clocks of margin on both sides
  task sel(input logic v);
    repeat (4) @(negedge i_clk);
    o_cs_n = v;
    if (v) o_lane0 = ~o_lane0; // Released line shows no stale bit
    repeat (4) @(negedge i_clk);
  endtask

  // One byte out and in, 200 ns link period, clock still between bytes of no frame
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_lane0 = tx[i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      rx[i] = i_lane1_oe ? i_lane1_out : ~i_lane1_out; // Undriven line shows no stale bit
      o_sck = 1'b0;
    end
  endtask
endmodule

// [verification/sfd_flash_front_tb.sv]
// Self-checking bench for the flash front end with host and array models
module sfd_flash_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfd_pkg::*;
  logic i_clk, i_rst, i_op_in_progress, i_mem_valid; // Design inputs
  logic sck, cs_n, lane0, lane1_out, lane1_oe, mem_rd, sleep, soft_rst, latch, rst_seen;
  logic [7:0] i_mem_data, opcode, rx; // Array byte, opcode, received byte
  logic [18:0] mem_addr; // Array address
  sfd_cmd_t cmd, seen; // Pulses and their sticky copy
  int bad_count, n_tests, cycles;

  sfd_flash_front sfd_flash_front_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_sck(sck), .i_cs_n(cs_n), .i_lane0(lane0), .o_lane1_out(lane1_out),
    .o_lane1_oe(lane1_oe), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_data(i_mem_data),
    .i_mem_valid(i_mem_valid), .i_op_in_progress(i_op_in_progress), .o_cmd(cmd),
    .o_opcode(opcode), .o_write_latch(latch), .o_sleep(sleep), .o_soft_rst(soft_rst));
  sfd_host_model sfd_host_model_inst (.i_clk(i_clk), .i_lane1_out(lane1_out),
    .i_lane1_oe(lane1_oe), .o_sck(sck),
    .o_cs_n(cs_n), .o_lane0(lane0));

  // ==========================================================
  // Clock, array model, pulse capture and hang guard
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] pat(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h0, a[18:16]} ^ 8'ha5;
  endfunction
  always @(negedge i_clk) begin
    i_mem_valid <= mem_rd; // Answer exactly one clock later
    i_mem_data <= pat(mem_addr);
  end
  always @(posedge i_clk) begin
    seen <= seen | cmd;
    rst_seen <= rst_seen | soft_rst;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Compare and report
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: value %h want %h", $time, got, exp);
    end
  endtask
  task chk_cmd(input sfd_cmd_t got, input sfd_cmd_t exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: pulses %h want %h", $time, got, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One opcode-only frame, pulses gathered in seen
  task frame(input logic [7:0] op);
    seen = '0;
    rst_seen = 1'b0;
    sfd_host_model_inst.sel(1'b0);
    sfd_host_model_inst.xfer(op, rx);
    sfd_host_model_inst.sel(1'b1);
    repeat (4) @(negedge i_clk);
  endtask

  // Opcode walk: latch gating, plain decodes, sleep and wake, soft reset
  task t_decode;
    logic [7:0] ops [24];
    int bits [24];
    logic lat, slp;
    sfd_cmd_t exp;
    ops = '{8'h06, 8'h02, 8'h02, 8'h06, 8'h32, 8'h06, 8'h38, 8'h06, 8'hc7, 8'h06, 8'h60, 8'h0b,
      8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h75, 8'hb0, 8'h9f, 8'hb9, 8'h9f, 8'hab, 8'h66, 8'h99};
    bits = '{-1, 6, -1, -1, 5, -1, 5, -1, 4, -1, 4, 11, 10, 9, 8, 7, 3, 3, 0, 2, -1, 1, -1, -1};
    lat = 1'b0;
    slp = 1'b0;
    for (int k = 0; k < 24; k++) begin
      frame(ops[k]);
      exp = '0;
      if (bits[k] >= 0) exp[bits[k]] = 1'b1;
      if (ops[k] == 8'h06) lat = 1'b1;
      if (ops[k] inside {8'h02, 8'h32, 8'h38, 8'hc7, 8'h60}) lat = 1'b0;
      slp = (ops[k] == 8'hb9) | (slp & (ops[k] != 8'hab));
      chk_cmd(seen, exp);
      if (bits[k] >= 0) chk_byte(opcode, ops[k]);
      chk_byte({7'h0, latch}, {7'h0, lat});
      chk_byte({7'h0, sleep}, {7'h0, slp});
      chk_byte({7'h0, rst_seen}, {7'h0, ops[k] == 8'h99});
    end
    $display("test decode done");
  endtask

  // Normal read over the top of the array with input noise, or refused while busy
  task t_read(input logic busy);
    logic [23:0] a;
    logic [18:0] e;
    a = 24'hf7fffe;
    e = a[18:0];
    seen = '0;
    i_op_in_progress = busy;
    sfd_host_model_inst.sel(1'b0);
    sfd_host_model_inst.xfer(8'h03, rx);
    for (int b = 2; b >= 0; b--) sfd_host_model_inst.xfer(a[8*b +: 8], rx);
    for (int n = 0; n < 4; n++) begin
      sfd_host_model_inst.xfer(n[0] ? 8'hff : 8'h00, rx);
      if (!busy) chk_byte(rx, pat(e));
      chk_byte({7'h0, lane1_oe}, {7'h0, ~busy});
      e = e + 19'h1;
    end
    sfd_host_model_inst.sel(1'b1);
    repeat (4) @(negedge i_clk);
    chk_byte({7'h0, lane1_oe}, 8'h00);
    chk_byte({7'h0, seen.read_cmd}, {7'h0, ~busy});
    i_op_in_progress = 1'b0;
    $display("test read busy=%0b done", busy);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_op_in_progress = 1'b0;
    i_mem_valid = 1'b0;
    i_mem_data = 8'h00;
    seen = '0;
    rst_seen = 1'b0;
    cycles = 0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_decode();
    t_read(1'b0);
    t_read(1'b1);
    results();
  end
endmodule
